// ### include/umsi_pkg.sv
// constants for the modem status / interrupt identification logic of one uart channel
// assumes an 8-bit host bus with a 3-bit register address and one device clock
package umsi_pkg;

	// register addresses on the host bus (read side and write side)
	localparam logic [2:0] ADDR_IRQ_ENABLE_MASK = 3'h1;
	localparam logic [2:0] ADDR_IRQ_SOURCE_IDENT = 3'h2;
	localparam logic [2:0] ADDR_MODEM_LINE_STATE = 3'h6;

	// values after reset
	localparam logic [7:0] IRQ_ENABLE_MASK_RESET = 8'h00;
	localparam logic [7:0] READ_DATA_RESET = 8'h00;

	// enable mask field positions
	localparam int IEN_RX_DATA = 0;
	localparam int IEN_TX_HOLD = 1;
	localparam int IEN_RX_LINE = 2;
	localparam int IEN_MODEM = 3;
	localparam int IEN_SLEEP = 4;
	localparam int IEN_XOFF = 5;
	localparam int IEN_RTS = 6;
	localparam int IEN_CTS = 7;
	// lowest bit of the nibble that only takes writes with enhanced functions on
	localparam int IEN_ENH_LSB = 4;

	// modem line control bit positions
	localparam int MLC_DTR = 0;
	localparam int MLC_RTS = 1;
	localparam int MLC_FIFO_RDY = 2;
	localparam int MLC_IRQ_OP = 3;
	localparam int MLC_LOOPBACK = 4;

	// modem line indices inside the 4-bit status/delta groups
	localparam int LINE_CTS = 0;
	localparam int LINE_DSR = 1;
	localparam int LINE_RI = 2;
	localparam int LINE_CD = 3;

	// identification codes for bits 5..0, highest priority first
	localparam logic [5:0] IDENT_RX_LINE = 6'h06;
	localparam logic [5:0] IDENT_RX_TIMEOUT = 6'h0c;
	localparam logic [5:0] IDENT_RX_DATA = 6'h04;
	localparam logic [5:0] IDENT_TX_HOLD = 6'h02;
	localparam logic [5:0] IDENT_MODEM = 6'h00;
	localparam logic [5:0] IDENT_XOFF = 6'h10;
	localparam logic [5:0] IDENT_CTS_RTS = 6'h20;
	localparam logic [5:0] IDENT_NONE = 6'h01;

endpackage

// ### src/umsi_line_delta.sv
// one modem line: holds the previous level of its source and a sticky change flag
// assumes the source is already active high and synchronous to clock_in
`timescale 1ns/1ns
`default_nettype none

module umsi_line_delta #(
	parameter bit RISE_ONLY = 1'b0
) (
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic level_in,
	input wire logic clear_in,
	output logic delta_out
);

	logic prev;
	logic next_prev;
	logic next_delta;
	logic change;

	// a change seen in the clearing cycle survives the clear
	always_comb begin
		next_prev = level_in;
		change = RISE_ONLY ? (level_in & ~prev) : (level_in ^ prev);
		next_delta = change | (delta_out & ~clear_in);
	end

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			prev <= 1'b0;
			delta_out <= 1'b0;
		end else begin
			prev <= next_prev;
			delta_out <= next_delta;
		end
	end

endmodule

`default_nettype wire

// ### src/umsi_top.sv
// modem status, interrupt enable mask and interrupt identification for one uart channel
// assumes host strobes and modem pins are synchronous to clock_in; fifo, serial
// engine and flow control sit outside and report their conditions on plain inputs
`timescale 1ns/1ns
`default_nettype none

// How it works
// - status bits are inverted active-low modem pins
// - loop-back takes status from control bits 3,2,0,1
// - cd/dsr/cts deltas set on change, clear on read
// - ring delta sets only on low-to-high
// - each enable bit but bit 4 gates its own source; bit 0 gates both rx data and rx timeout
// - enable and sleep bits reset to zero
// - enable bit 4 drives sleep mode
// - upper enable nibble writable only with enhanced functions
// - re-enabling transmit holding raises nothing new
// - interrupt output active for any enabled pending source
// - identification register is read-only, writes ignored
// - identification bits 7:6 mirror fifo enable
// - identification bit 0 low when interrupt pending
// - bit 4 flags xoff or special character
// - bit 5 flags cts/rts rise, lowest priority
// - bits 3:1 encode the selected source
// - receiver line status is top priority, 000110
// - levels two to five use their fixed codes
// - control bit 4 selects internal loop-back
module umsi_top (
	input wire logic clock_in,
	input wire logic nrst_in,
	// host bus, active-low strobes
	input wire logic chip_sel_n_in,
	input wire logic rd_n_in,
	input wire logic wr_n_in,
	input wire logic [2:0] addr_in,
	input wire logic [7:0] data_in,
	output logic [7:0] data_out,
	output logic data_oe_n_out,
	// active-low modem pins
	input wire logic cd_n_in,
	input wire logic ri_n_in,
	input wire logic dsr_n_in,
	input wire logic cts_n_in,
	input wire logic rts_n_in,
	// settings held by neighbouring registers
	input wire logic [4:0] modem_line_control_in,
	input wire logic enhanced_func_en_in,
	input wire logic fifo_enable_in,
	// conditions from the receive and transmit paths
	input wire logic rx_line_error_in,
	input wire logic rx_timeout_in,
	input wire logic rx_data_ready_in,
	input wire logic tx_below_thresh_in,
	input wire logic tx_hold_write_in,
	input wire logic xoff_detect_in,
	// outputs
	output logic irq_out,
	output logic sleep_out
);

	// reset release through two flops; the first is read only by the second
	logic rst_meta;
	logic rst_n;

	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	// bus strobe edges: one access per strobe, so a long read clears the deltas once
	logic rd_level;
	logic wr_level;
	logic rd_prev;
	logic wr_prev;
	logic rd_take;
	logic wr_take;

	assign rd_level = ~chip_sel_n_in & ~rd_n_in;
	assign wr_level = ~chip_sel_n_in & ~wr_n_in;
	assign rd_take = rd_level & ~rd_prev;
	assign wr_take = wr_level & ~wr_prev;

	always_ff @(posedge clock_in or negedge rst_n) begin
		if (!rst_n) begin
			rd_prev <= 1'b0;
			wr_prev <= 1'b0;
		end else begin
			rd_prev <= rd_level;
			wr_prev <= wr_level;
		end
	end

	// modem line sources, active high
	logic loopback;
	logic [3:0] line_level;
	logic [3:0] line_delta;
	logic status_read;

	assign loopback = modem_line_control_in[umsi_pkg::MLC_LOOPBACK];
	assign status_read = rd_take & (addr_in == umsi_pkg::ADDR_MODEM_LINE_STATE);

	// loop-back swaps the pins for the control bits
	always_comb begin
		if (loopback) begin
			line_level[umsi_pkg::LINE_CD] = modem_line_control_in[umsi_pkg::MLC_IRQ_OP];
			line_level[umsi_pkg::LINE_RI] = modem_line_control_in[umsi_pkg::MLC_FIFO_RDY];
			line_level[umsi_pkg::LINE_DSR] = modem_line_control_in[umsi_pkg::MLC_DTR];
			line_level[umsi_pkg::LINE_CTS] = modem_line_control_in[umsi_pkg::MLC_RTS];
		end else begin
			line_level[umsi_pkg::LINE_CD] = ~cd_n_in;
			line_level[umsi_pkg::LINE_RI] = ~ri_n_in;
			line_level[umsi_pkg::LINE_DSR] = ~dsr_n_in;
			line_level[umsi_pkg::LINE_CTS] = ~cts_n_in;
		end
	end

	// one delta tracker per line; ring only counts rising edges of its source
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_line
			umsi_line_delta #(
				.RISE_ONLY(gi == umsi_pkg::LINE_RI)
			) u_delta (
				.clock_in(clock_in),
				.rst_n_in(rst_n),
				.level_in(line_level[gi]),
				.clear_in(status_read),
				.delta_out(line_delta[gi])
			);
		end
	endgenerate

	// enable mask and sleep bit
	logic [7:0] irq_enable_mask;
	logic [7:0] next_irq_enable_mask;
	logic mask_write;

	assign mask_write = wr_take & (addr_in == umsi_pkg::ADDR_IRQ_ENABLE_MASK);

	// upper nibble frozen unless enhanced functions are on
	always_comb begin
		next_irq_enable_mask = irq_enable_mask;
		if (mask_write) begin
			next_irq_enable_mask[3:0] = data_in[3:0];
			if (enhanced_func_en_in) begin
				next_irq_enable_mask[7:4] = data_in[7:4];
			end
		end
	end

	always_ff @(posedge clock_in or negedge rst_n) begin
		if (!rst_n) begin
			irq_enable_mask <= umsi_pkg::IRQ_ENABLE_MASK_RESET;
		end else begin
			irq_enable_mask <= next_irq_enable_mask;
		end
	end

	// sticky event sources: transmit holding, xoff and cts/rts rise
	logic tx_pend;
	logic xoff_pend;
	logic [1:0] ctsrts_pend;
	logic [1:0] ctsrts_mask;
	logic next_tx_pend;
	logic next_xoff_pend;
	logic [1:0] next_ctsrts_pend;
	logic cts_n_prev;
	logic rts_n_prev;
	logic tx_below_prev;
	logic xoff_prev;
	logic ident_read;
	logic [5:0] ident_code;

	assign ident_read = rd_take & (addr_in == umsi_pkg::ADDR_IRQ_SOURCE_IDENT);
	assign ctsrts_mask = {irq_enable_mask[umsi_pkg::IEN_RTS],
		irq_enable_mask[umsi_pkg::IEN_CTS]};

	// tx interrupt follows the fall below threshold, not the level, so toggling
	// the enable bit cannot invent a fresh one; a read that reports a source
	// retires it, but a new event in the same cycle wins
	always_comb begin
		next_tx_pend = tx_pend;
		if (ident_read && (ident_code == umsi_pkg::IDENT_TX_HOLD)) begin
			next_tx_pend = 1'b0;
		end
		if (tx_hold_write_in) begin
			next_tx_pend = 1'b0;
		end
		if (tx_below_thresh_in && !tx_below_prev) begin
			next_tx_pend = 1'b1;
		end
		next_xoff_pend = xoff_pend;
		if (ident_read && (ident_code == umsi_pkg::IDENT_XOFF)) begin
			next_xoff_pend = 1'b0;
		end
		if (xoff_detect_in && !xoff_prev) begin
			next_xoff_pend = 1'b1;
		end
		// bit 0 cts rise, bit 1 rts rise; a report retires only the enabled ones
		next_ctsrts_pend = ctsrts_pend;
		if (ident_read && (ident_code == umsi_pkg::IDENT_CTS_RTS)) begin
			next_ctsrts_pend = ctsrts_pend & ~ctsrts_mask;
		end
		if (cts_n_in && !cts_n_prev) begin
			next_ctsrts_pend[0] = 1'b1;
		end
		if (rts_n_in && !rts_n_prev) begin
			next_ctsrts_pend[1] = 1'b1;
		end
	end

	// pin history starts inactive high so reset itself is no edge
	always_ff @(posedge clock_in or negedge rst_n) begin
		if (!rst_n) begin
			tx_pend <= 1'b0;
			xoff_pend <= 1'b0;
			ctsrts_pend <= 2'b00;
			cts_n_prev <= 1'b1;
			rts_n_prev <= 1'b1;
			tx_below_prev <= 1'b0;
			xoff_prev <= 1'b0;
		end else begin
			tx_pend <= next_tx_pend;
			xoff_pend <= next_xoff_pend;
			ctsrts_pend <= next_ctsrts_pend;
			cts_n_prev <= cts_n_in;
			rts_n_prev <= rts_n_in;
			tx_below_prev <= tx_below_thresh_in;
			xoff_prev <= xoff_detect_in;
		end
	end

	// enabled sources and priority selection
	logic en_rx_line;
	logic en_rx_timeout;
	logic en_rx_data;
	logic en_tx_hold;
	logic en_modem;
	logic en_xoff;
	logic en_ctsrts;
	logic any_pending;

	always_comb begin
		en_rx_line = rx_line_error_in & irq_enable_mask[umsi_pkg::IEN_RX_LINE];
		en_rx_timeout = rx_timeout_in & irq_enable_mask[umsi_pkg::IEN_RX_DATA];
		en_rx_data = rx_data_ready_in & irq_enable_mask[umsi_pkg::IEN_RX_DATA];
		en_tx_hold = tx_pend & irq_enable_mask[umsi_pkg::IEN_TX_HOLD];
		en_modem = (|line_delta) & irq_enable_mask[umsi_pkg::IEN_MODEM];
		en_xoff = xoff_pend & irq_enable_mask[umsi_pkg::IEN_XOFF];
		en_ctsrts = |(ctsrts_pend & ctsrts_mask);
	end

	// one source at a time, highest first; the next shows once it clears
	always_comb begin
		any_pending = 1'b1;
		if (en_rx_line) begin
			ident_code = umsi_pkg::IDENT_RX_LINE;
		end else if (en_rx_timeout) begin
			ident_code = umsi_pkg::IDENT_RX_TIMEOUT;
		end else if (en_rx_data) begin
			ident_code = umsi_pkg::IDENT_RX_DATA;
		end else if (en_tx_hold) begin
			ident_code = umsi_pkg::IDENT_TX_HOLD;
		end else if (en_modem) begin
			ident_code = umsi_pkg::IDENT_MODEM;
		end else if (en_xoff) begin
			ident_code = umsi_pkg::IDENT_XOFF;
		end else if (en_ctsrts) begin
			ident_code = umsi_pkg::IDENT_CTS_RTS;
		end else begin
			ident_code = umsi_pkg::IDENT_NONE;
			any_pending = 1'b0;
		end
	end

	// read data mux; reads are captured at the strobe edge and held for the host
	logic [7:0] next_data;
	logic [7:0] line_state_view;
	logic [7:0] ident_view;
	logic next_oe_n;
	logic next_irq;
	logic next_sleep;

	assign line_state_view = {line_level[umsi_pkg::LINE_CD], line_level[umsi_pkg::LINE_RI],
		line_level[umsi_pkg::LINE_DSR], line_level[umsi_pkg::LINE_CTS],
		line_delta[umsi_pkg::LINE_CD], line_delta[umsi_pkg::LINE_RI],
		line_delta[umsi_pkg::LINE_DSR], line_delta[umsi_pkg::LINE_CTS]};
	assign ident_view = {fifo_enable_in, fifo_enable_in, ident_code};

	// writes to the identification address fall through untouched
	always_comb begin
		next_data = data_out;
		if (rd_take) begin
			case (addr_in)
				umsi_pkg::ADDR_IRQ_ENABLE_MASK: next_data = irq_enable_mask;
				umsi_pkg::ADDR_IRQ_SOURCE_IDENT: next_data = ident_view;
				umsi_pkg::ADDR_MODEM_LINE_STATE: next_data = line_state_view;
				default: next_data = umsi_pkg::READ_DATA_RESET;
			endcase
		end
		next_oe_n = ~rd_level;
		next_irq = any_pending;
		next_sleep = irq_enable_mask[umsi_pkg::IEN_SLEEP];
	end

	always_ff @(posedge clock_in or negedge rst_n) begin
		if (!rst_n) begin
			data_out <= umsi_pkg::READ_DATA_RESET;
			data_oe_n_out <= 1'b1;
			irq_out <= 1'b0;
			sleep_out <= 1'b0;
		end else begin
			data_out <= next_data;
			data_oe_n_out <= next_oe_n;
			irq_out <= next_irq;
			sleep_out <= next_sleep;
		end
	end

endmodule

`default_nettype wire

// ### tb/umsi_chk_sva.sv
// checker: bus, mask, status and ident relations at the block's ports
// assumes the host leaves one idle strobe cycle between accesses
`timescale 1ns/1ns
`default_nettype none
module umsi_chk (
	input wire logic clock_in,
	input wire logic nrst_in,
	input wire logic chip_sel_n_in,
	input wire logic rd_n_in,
	input wire logic wr_n_in,
	input wire logic [2:0] addr_in,
	input wire logic [7:0] data_in,
	input wire logic [7:0] data_out,
	input wire logic data_oe_n_out,
	input wire logic cd_n_in,
	input wire logic ri_n_in,
	input wire logic dsr_n_in,
	input wire logic cts_n_in,
	input wire logic [4:0] modem_line_control_in,
	input wire logic enhanced_func_en_in,
	input wire logic fifo_enable_in,
	input wire logic rx_line_error_in,
	input wire logic irq_out,
	input wire logic sleep_out
);
	logic rd_q, wr_q, rd_go, wr_go;
	logic [7:0] mask, next_mask;
	logic [3:0] pins;
	logic [4:0] mc;
	default clocking @(posedge clock_in); endclocking
	default disable iff (!nrst_in);
	// accesses count on the first low strobe cycle only
	assign rd_go = !(chip_sel_n_in | rd_n_in) && rd_q;
	assign wr_go = !(chip_sel_n_in | wr_n_in) && wr_q;
	assign pins = {cd_n_in, ri_n_in, dsr_n_in, cts_n_in};
	assign mc = modem_line_control_in;
	// shadow of the mask, so gating can be judged without the body
	always_comb begin
		next_mask = mask;
		if (wr_go && addr_in == umsi_pkg::ADDR_IRQ_ENABLE_MASK) begin
			next_mask[3:0] = data_in[3:0];
			if (enhanced_func_en_in) begin
				next_mask[7:4] = data_in[7:4];
			end
		end
	end
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			mask <= 8'h00;
			rd_q <= 1'b1;
			wr_q <= 1'b1;
		end else begin
			mask <= next_mask;
			rd_q <= chip_sel_n_in | rd_n_in;
			wr_q <= chip_sel_n_in | wr_n_in;
		end
	end
	oe_read_a: assert property (rd_go |=> !data_oe_n_out)
		else $error("bus not driven after read");
	oe_idle_a: assert property ((chip_sel_n_in | rd_n_in) |=> data_oe_n_out)
		else $error("bus driven without read");
	sleep_bit_a: assert property (sleep_out == $past(mask[4]))
		else $error("sleep does not follow mask");
	line_irq_a: assert property (rx_line_error_in && mask[2] |=> irq_out)
		else $error("no irq for line error");
	quiet_mask_a: assert property ((mask == 8'h00) [*2] |=> !irq_out)
		else $error("irq with all sources masked");
	line_ident_a: assert property (rd_go && addr_in == umsi_pkg::ADDR_IRQ_SOURCE_IDENT &&
		mask[2] && rx_line_error_in && $stable({rx_line_error_in, fifo_enable_in, mask})
		|=> data_out == {{2{$past(fifo_enable_in)}}, umsi_pkg::IDENT_RX_LINE})
		else $error("line error not reported first");
	pin_state_a: assert property (rd_go && addr_in == umsi_pkg::ADDR_MODEM_LINE_STATE &&
		!mc[4] && $stable({pins, mc}) |=> data_out[7:4] == ~$past(pins))
		else $error("status not inverted pins");
	loop_state_a: assert property (rd_go && addr_in == umsi_pkg::ADDR_MODEM_LINE_STATE &&
		mc[4] && $stable({pins, mc})
		|=> data_out[7:4] == {$past(mc[3]), $past(mc[2]), $past(mc[0]), $past(mc[1])})
		else $error("status not from control bits");
endmodule
`default_nettype wire

// ### tb/umsi_host.sv
// host processor model: single byte reads and writes on the strobe bus
// assumes the block answers one edge after it takes an access
`timescale 1ns/1ns
`default_nettype none
module umsi_host (
	input wire logic clock_in,
	input wire logic [7:0] data_out_in,
	output logic chip_sel_n_out,
	output logic rd_n_out,
	output logic wr_n_out,
	output logic [2:0] addr_out,
	output logic [7:0] data_in_out
);
	// idle bus from time zero
	initial begin
		chip_sel_n_out = 1'b1;
		rd_n_out = 1'b1;
		wr_n_out = 1'b1;
		addr_out = 3'h0;
		data_in_out = 8'h5a;
	end
	// strobe one edge, taken the next; the answer is read while the strobe still
	// stands, and only then is the bus released; released data flips
	task automatic xfer(input logic wr, input logic [2:0] a, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge clock_in);
		chip_sel_n_out <= 1'b0;
		rd_n_out <= wr;
		wr_n_out <= !wr;
		addr_out <= a;
		data_in_out <= d;
		repeat (2) @(posedge clock_in);
		q = data_out_in;
		chip_sel_n_out <= 1'b1;
		rd_n_out <= 1'b1;
		wr_n_out <= 1'b1;
		data_in_out <= ~d;
		@(posedge clock_in);
	endtask
endmodule
`default_nettype wire

// ### tb/testbench.sv
// top bench: random and corner traffic through the host model, self checked
// assumes the checker and host model are compiled before it
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic clock_in = 1'b0, nrst_in = 1'b0;
	logic chip_sel_n_in, rd_n_in, wr_n_in, data_oe_n_out, irq_out, sleep_out;
	logic [2:0] addr_in;
	logic [7:0] data_in, data_out, q, m;
	logic cd_n_in = 1'b1, ri_n_in = 1'b1, dsr_n_in = 1'b1, cts_n_in = 1'b1, rts_n_in = 1'b1;
	logic [4:0] modem_line_control_in = 5'h00;
	logic enhanced_func_en_in = 1'b0, fifo_enable_in = 1'b0, rx_line_error_in = 1'b0;
	logic rx_timeout_in = 1'b0, rx_data_ready_in = 1'b0, tx_below_thresh_in = 1'b0;
	logic tx_hold_write_in = 1'b0, xoff_detect_in = 1'b0;
	logic [31:0] seed = 32'h38a70fdc;
	logic [3:0] src, prv;
	logic [5:0] codes [8] = '{umsi_pkg::IDENT_RX_LINE, umsi_pkg::IDENT_RX_TIMEOUT,
		umsi_pkg::IDENT_RX_DATA, umsi_pkg::IDENT_TX_HOLD, umsi_pkg::IDENT_MODEM,
		umsi_pkg::IDENT_XOFF, umsi_pkg::IDENT_CTS_RTS, umsi_pkg::IDENT_NONE};
	int err_count = 0, n_checks = 0;
	umsi_top i_dut (.clock_in, .nrst_in, .chip_sel_n_in, .rd_n_in, .wr_n_in, .addr_in,
		.data_in, .data_out, .data_oe_n_out, .cd_n_in, .ri_n_in, .dsr_n_in, .cts_n_in,
		.rts_n_in, .modem_line_control_in, .enhanced_func_en_in, .fifo_enable_in,
		.rx_line_error_in, .rx_timeout_in, .rx_data_ready_in, .tx_below_thresh_in,
		.tx_hold_write_in, .xoff_detect_in, .irq_out, .sleep_out);
	umsi_host i_host (.clock_in, .data_out_in(data_out), .chip_sel_n_out(chip_sel_n_in),
		.rd_n_out(rd_n_in), .wr_n_out(wr_n_in), .addr_out(addr_in), .data_in_out(data_in));
	// 25 MHz clock
	always #20 clock_in = ~clock_in;
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	// status source: inverted pins, or control bits in loop-back
	function automatic logic [3:0] src_of(input logic [3:0] pn, input logic [4:0] c);
		return c[4] ? {c[3], c[2], c[0], c[1]} : ~pn;
	endfunction
	task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] x);
		n_checks++;
		if (s !== x) begin
			err_count++;
			$display("unexpected %s expected %h seen %h", nm, x, s);
		end
	endtask
	task automatic test_done;
		if (err_count == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic rd(input logic [2:0] a);
		i_host.xfer(1'b0, a, 8'h00, q);
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		i_host.xfer(1'b1, a, d, q);
	endtask
	// watchdog well beyond the expected run
	initial begin
		#2000000;
		err_count++;
		test_done();
	end
	// main sequence
	initial begin
		repeat (2) @(posedge clock_in);
		nrst_in <= 1'b1;
		repeat (3) @(posedge clock_in);
		chk("sleep", {7'h00, sleep_out}, 8'h00);
		rd(3'h1);
		chk("mask", q, 8'h00);
		rd(3'h7);
		chk("unmapped", q, 8'h00);
		m = 8'h00;
		for (int i = 0; i < 10; i++) begin
			seed = xs(seed);
			enhanced_func_en_in <= seed[8];
			wr(3'h1, seed[7:0]);
			m = seed[8] ? seed[7:0] : {m[7:4], seed[3:0]};
			rd(3'h1);
			chk("mask", q, m);
			chk("sleep", {7'h00, sleep_out}, {7'h00, m[4]});
		end
		// every source pending at once, then retired one by one
		enhanced_func_en_in <= 1'b1;
		fifo_enable_in <= seed[9];
		wr(3'h1, 8'hff);
		{rx_line_error_in, rx_timeout_in, rx_data_ready_in} <= 3'h7;
		{tx_below_thresh_in, xoff_detect_in, cts_n_in} <= 3'h6;
		repeat (2) @(posedge clock_in);
		cts_n_in <= 1'b1;
		wr(3'h2, 8'h00);
		for (int i = 0; i < 8; i++) begin
			fifo_enable_in <= seed[9] ^ i[0];
			case (i)
				1: rx_line_error_in <= 1'b0;
				2: rx_timeout_in <= 1'b0;
				3: rx_data_ready_in <= 1'b0;
				5: rd(3'h6);
				default: ;
			endcase
			repeat (3) @(posedge clock_in);
			chk("irq", {7'h00, irq_out}, {7'h00, i < 7});
			rd(3'h2);
			chk("ident", q, {{2{seed[9] ^ i[0]}}, codes[i]});
		end
		wr(3'h1, 8'hfd);
		wr(3'h1, 8'hff);
		repeat (3) @(posedge clock_in);
		chk("irq", {7'h00, irq_out}, 8'h00);
		// a fresh fall below threshold latches again; a holding write retires it
		tx_below_thresh_in <= 1'b0;
		@(posedge clock_in);
		tx_below_thresh_in <= 1'b1;
		repeat (3) @(posedge clock_in);
		chk("irq", {7'h00, irq_out}, 8'h01);
		tx_hold_write_in <= 1'b1;
		@(posedge clock_in);
		tx_hold_write_in <= 1'b0;
		repeat (3) @(posedge clock_in);
		chk("irq", {7'h00, irq_out}, 8'h00);
		// rts rise with only its own enable off stays quiet until that bit is set
		wr(3'h1, 8'hbf);
		rts_n_in <= 1'b0;
		@(posedge clock_in);
		rts_n_in <= 1'b1;
		repeat (3) @(posedge clock_in);
		chk("irq", {7'h00, irq_out}, 8'h00);
		wr(3'h1, 8'hff);
		repeat (3) @(posedge clock_in);
		chk("irq", {7'h00, irq_out}, 8'h01);
		rd(3'h2);
		chk("ident", q, {{2{fifo_enable_in}}, umsi_pkg::IDENT_CTS_RTS});
		// random modem lines, normal and loop-back
		wr(3'h1, 8'h00);
		prv = src_of(4'hf, 5'h00);
		for (int i = 0; i < 24; i++) begin
			seed = xs(seed);
			{cd_n_in, ri_n_in, dsr_n_in, cts_n_in} <= seed[3:0];
			rts_n_in <= seed[4];
			modem_line_control_in <= seed[9:5];
			repeat (3) @(posedge clock_in);
			src = src_of(seed[3:0], seed[9:5]);
			rd(3'h6);
			chk("status", q, {src, src[3] ^ prv[3], src[2] & ~prv[2], src[1:0] ^ prv[1:0]});
			prv = src;
		end
		test_done();
	end
endmodule
bind umsi_top umsi_chk i_chk (.clock_in, .nrst_in, .chip_sel_n_in, .rd_n_in, .wr_n_in,
	.addr_in, .data_in, .data_out, .data_oe_n_out, .cd_n_in, .ri_n_in, .dsr_n_in, .cts_n_in,
	.modem_line_control_in, .enhanced_func_en_in, .fifo_enable_in, .rx_line_error_in,
	.irq_out, .sleep_out);
`default_nettype wire
